// ===== design/fcsp_port.sv
// serial port holding the shared filter corner-frequency code
// assumes host drives serial clock, data and frame select; all pins are asynchronous
`timescale 1ns/100ps
`default_nettype none

module fcsp_port
   import fcsp_pkg::*;
(
   // clock and reset
   input wire logic i_mclk,
   input wire logic i_rst_b,
   // serial pins
   input wire logic i_serial_clk,
   input wire logic i_serial_data,
   input wire logic i_frame_select_n,
   output logic o_serial_readback_out,
   // filter control
   output logic [FCSP_CODE_W-1:0] o_filter_corner_code,
   output logic [FCSP_CODE_W-1:0] o_corner_mhz
);
   ////////////////////////////////////////////////////////////////////////////
   // pin synchronisation
   logic [2:0] pins_sync;
   logic sclk_s;
   logic sdata_s;
   logic fsel_n_s;
   logic sclk_prev_reg;
   logic fsel_n_prev_reg;

   // frame select passes inverted so the synchroniser's reset value of zero
   // reads as an idle frame; otherwise a false frame opens after every reset
   fcsp_sync #(.WIDTH(3)) u_sync
   (
      .i_mclk(i_mclk),
      .i_rst_b(i_rst_b),
      .i_async({i_serial_clk, i_serial_data, ~i_frame_select_n}),
      .o_sync(pins_sync)
   );

   assign sclk_s = pins_sync[2];
   assign sdata_s = pins_sync[1];
   assign fsel_n_s = ~pins_sync[0];

   ////////////////////////////////////////////////////////////////////////////
   // edge decode
   wire sclk_rise = sclk_s & ~sclk_prev_reg;
   wire sclk_fall = ~sclk_s & sclk_prev_reg;
   wire frame_end = fsel_n_s & ~fsel_n_prev_reg;
   wire frame_active = ~fsel_n_s;

   function automatic logic [4:0] fcsp_corner(input logic [4:0] code);
      fcsp_corner = (code > FCSP_CODE_MAX) ? FCSP_CODE_MAX + 5'h01 : code + 5'h01;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // state
   fcsp_state_t state_reg;
   fcsp_state_t state_next;
   logic [4:0] shift_reg;
   logic [4:0] shift_next;
   logic [4:0] cnt_reg;
   logic [4:0] cnt_next;
   logic [4:0] code_reg;
   logic [4:0] code_next;
   logic out_reg;
   logic out_next;

   ////////////////////////////////////////////////////////////////////////////
   // transfer decode
   wire bits_left = (cnt_reg < FCSP_BIT_CNT);
   wire dir_take = (state_reg == FCSP_DIR) & sclk_rise;
   wire write_take = (state_reg == FCSP_WRITE) & sclk_rise & bits_left;
   wire read_take = (state_reg == FCSP_READ) & sclk_fall & bits_left;
   // only a write with all five bits in counts; a cut frame leaves the code alone
   wire write_done = frame_end & (state_reg == FCSP_WRITE) & (cnt_reg == FCSP_BIT_CNT);

   ////////////////////////////////////////////////////////////////////////////
   // next state
   always_comb
   begin
      state_next = state_reg;
      shift_next = shift_reg;
      cnt_next = cnt_reg;
      code_next = code_reg;
      out_next = out_reg;
      if (!frame_active)
      begin
         if (write_done)
            code_next = shift_reg;
         state_next = FCSP_IDLE;
         cnt_next = 5'h00;
      end
      else
      begin
         unique case (state_reg)
            FCSP_IDLE:
               state_next = FCSP_DIR;
            FCSP_DIR:
               if (dir_take)
               begin
                  state_next = sdata_s ? FCSP_WRITE : FCSP_READ;
                  shift_next = code_reg;
                  cnt_next = 5'h00;
               end
            FCSP_WRITE:
               if (write_take)
               begin
                  shift_next = {sdata_s, shift_reg[4:1]};
                  cnt_next = cnt_reg + 5'h01;
               end
            FCSP_READ:
               if (read_take)
               begin
                  out_next = shift_reg[0];
                  shift_next = {1'b0, shift_reg[4:1]};
                  cnt_next = cnt_reg + 5'h01;
               end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // registers
   always_ff @(posedge i_mclk)
   begin
      if (!i_rst_b)
      begin
         state_reg <= FCSP_IDLE;
      end
      else
      begin
         state_reg <= state_next;
      end
   end

   always_ff @(posedge i_mclk)
   begin
      if (!i_rst_b)
      begin
         shift_reg <= 5'h00;
      end
      else
      begin
         shift_reg <= shift_next;
      end
   end

   always_ff @(posedge i_mclk)
   begin
      if (!i_rst_b)
      begin
         cnt_reg <= 5'h00;
      end
      else
      begin
         cnt_reg <= cnt_next;
      end
   end

   always_ff @(posedge i_mclk)
   begin
      if (!i_rst_b)
      begin
         code_reg <= FCSP_CODE_RST;
      end
      else
      begin
         code_reg <= code_next;
      end
   end

   always_ff @(posedge i_mclk)
   begin
      if (!i_rst_b)
      begin
         out_reg <= 1'b0;
      end
      else
      begin
         out_reg <= out_next;
      end
   end

   // history starts at the pins' idle levels so no false edge follows reset
   always_ff @(posedge i_mclk)
   begin
      if (!i_rst_b)
      begin
         sclk_prev_reg <= 1'b0;
         fsel_n_prev_reg <= 1'b1;
      end
      else
      begin
         sclk_prev_reg <= sclk_s;
         fsel_n_prev_reg <= fsel_n_s;
      end
   end

   // corner follows code_next so code and corner move on the same edge
   always_ff @(posedge i_mclk)
   begin
      if (!i_rst_b)
      begin
         o_corner_mhz <= fcsp_corner(FCSP_CODE_RST);
      end
      else
      begin
         o_corner_mhz <= fcsp_corner(code_next);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs
   assign o_filter_corner_code = code_reg;
   // readback is always driven; the host samples it in every transfer, but the bench checks it only after a read
   assign o_serial_readback_out = out_reg;
endmodule // fcsp_port
`default_nettype wire

// ===== design/fcsp_pkg.sv
// package for the filter corner serial port
// assumes a 100 MHz system clock that oversamples the host serial clock
package fcsp_pkg;
   localparam int FCSP_CODE_W = 5;
   localparam logic [4:0] FCSP_CODE_RST = 5'h00;
   localparam logic [4:0] FCSP_CODE_MAX = 5'h1D;
   localparam logic [4:0] FCSP_BIT_CNT = 5'h05;
   localparam int FCSP_SYNC_STAGES = 2;

   typedef enum logic [1:0]
   {
      FCSP_IDLE = 2'b00,
      FCSP_DIR = 2'b01,
      FCSP_WRITE = 2'b10,
      FCSP_READ = 2'b11
   } fcsp_state_t;
endpackage

// ===== design/fcsp_sync.sv
// two flip-flop synchroniser for a bundle of pin inputs
// assumes the inputs are asynchronous to i_mclk
`timescale 1ns/100ps
`default_nettype none
module fcsp_sync
#(
   parameter int WIDTH = 3
)
(
   // clock and reset
   input wire logic i_mclk,
   input wire logic i_rst_b,
   // pins
   input wire logic [WIDTH-1:0] i_async,
   output logic [WIDTH-1:0] o_sync
);
   logic [WIDTH-1:0] stage1_reg;

   always_ff @(posedge i_mclk)
   begin
      if (!i_rst_b)
      begin
         stage1_reg <= '0;
         o_sync <= '0;
      end
      else
      begin
         stage1_reg <= i_async;
         o_sync <= stage1_reg;
      end
   end
endmodule // fcsp_sync
`default_nettype wire

// ===== test/fcsp_port_checker.sv
// assertions on the corner serial port pins
// assumes a bind onto fcsp_port
`timescale 1ns/100ps
`default_nettype none
module fcsp_port_checker
   import fcsp_pkg::*;
(
   // clock, reset and pins
   input wire logic i_mclk,
   input wire logic i_rst_b,
   input wire logic i_serial_clk,
   input wire logic i_frame_select_n,
   input wire logic o_serial_readback_out,
   // filter control
   input wire logic [FCSP_CODE_W-1:0] o_filter_corner_code,
   input wire logic [FCSP_CODE_W-1:0] o_corner_mhz
);
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (!i_rst_b);
   wire logic [4:0] exp_mhz = (o_filter_corner_code > FCSP_CODE_MAX) ? 5'h1E : o_filter_corner_code + 5'h01;
   a_mhz_map: assert property ($stable(o_filter_corner_code) |-> o_corner_mhz == exp_mhz)
      else $error("corner mhz off");
   a_hold_low: assert property (!i_frame_select_n [*6] |=> $stable(o_filter_corner_code))
      else $error("code moved in frame");
   a_idle_hold: assert property (i_frame_select_n [*8] |=> $stable(o_filter_corner_code))
      else $error("code moved idle");
   a_rb_steady: assert property ((i_serial_clk && !i_frame_select_n) [*6] |=> $stable(o_serial_readback_out))
      else $error("readback moved");
   a_code_at_end: assert property ($changed(o_filter_corner_code) |-> i_frame_select_n)
      else $error("code moved with frame open");
   a_rb_low_clk: assert property ($changed(o_serial_readback_out) |-> !i_serial_clk && !i_frame_select_n)
      else $error("readback moved off a falling edge");
   a_mhz_span: assert property (o_corner_mhz >= 5'h01 && o_corner_mhz <= 5'h1E)
      else $error("corner mhz out of span");
endmodule // fcsp_port_checker
`default_nettype wire

// ===== test/fcsp_host.sv
// host model driving the serial pins
// assumes a 160 ns serial clock, idle low
`timescale 1ns/100ps
`default_nettype none
module fcsp_host
(
   // serial pins
   output var logic o_sclk = 1'b0,
   output var logic o_sdat = 1'b0,
   output var logic o_fsel_n = 1'b1,
   input wire logic i_rb
);
   // n below five cuts a write short
   task xfer(input logic w, input logic [4:0] d, input int n, output logic [4:0] q);
      int i;
      begin
         q = 5'h00;
         o_fsel_n = 1'b0;
         o_sdat = w;
         #80 o_sclk = 1'b1;
         for (i = 0; i < n; i++)
         begin
            #80 o_sclk = 1'b0;
            o_sdat = d[i];
            #80 q[i] = i_rb;
            o_sclk = 1'b1;
         end
         #80 o_sclk = 1'b0;
         o_sdat = ~o_sdat;
         #80 o_fsel_n = 1'b1;
         #80;
      end
   endtask
endmodule // fcsp_host
`default_nettype wire

// ===== test/test_fcsp_port.sv
// self-checking bench for the corner serial port
// assumes fcsp_host owns the serial pins
`timescale 1ns/100ps
`default_nettype none
module test_fcsp_port;
   import fcsp_pkg::*;
   logic i_mclk = 1'b0;
   logic i_rst_b = 1'b0;
   wire logic sclk, sdat, fsel_n, rb;
   wire logic [4:0] code, mhz;
   logic [4:0] q;
   logic [4:0] pat [4] = '{5'h1D, 5'h1E, 5'h1F, 5'h0A};
   int num_errors = 0;
   int check_count = 0;
   initial forever #5 i_mclk = ~i_mclk;
   fcsp_host i_host (.o_sclk(sclk), .o_sdat(sdat), .o_fsel_n(fsel_n), .i_rb(rb));
   fcsp_port i_dut (.i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_serial_clk(sclk), .i_serial_data(sdat),
      .i_frame_select_n(fsel_n), .o_serial_readback_out(rb), .o_filter_corner_code(code), .o_corner_mhz(mhz));
   task chk(input logic [4:0] got, input logic [4:0] exp);
      begin
         check_count++;
         if (got !== exp)
         begin
            num_errors++;
            $display("unexpected t=%0t got %h exp %h", $time, got, exp);
         end
      end
   endtask
   task print_verdict;
      begin
         $display("errors %0d checks %0d", num_errors, check_count);
         if (num_errors == 0 && check_count > 0)
            $display("All checks passed");
         else
            $display("Checks failed");
         $finish;
      end
   endtask
   initial
   begin
      repeat (6) @(negedge i_mclk);
      i_rst_b = 1'b1;
      repeat (3) @(negedge i_mclk);
      chk(code, FCSP_CODE_RST);
      chk(mhz, FCSP_CODE_RST + 5'h01);
      i_host.xfer(1'b0, 5'h00, 5, q);
      chk(q, FCSP_CODE_RST);
      foreach (pat[k])
      begin
         i_host.xfer(1'b1, pat[k], 5, q);
         chk(code, pat[k]);
         chk(mhz, (pat[k] > FCSP_CODE_MAX) ? 5'h1E : pat[k] + 5'h01);
         i_host.xfer(1'b0, 5'h00, 5, q);
         chk(q, pat[k]);
         chk(code, pat[k]);
      end
      i_host.xfer(1'b1, 5'h15, 3, q);
      chk(code, 5'h0A);
      i_host.xfer(1'b0, 5'h00, 5, q);
      chk(q, 5'h0A);
      // a reset in mid-run drops the code back and opens no frame
      i_rst_b = 1'b0;
      repeat (6) @(negedge i_mclk);
      i_rst_b = 1'b1;
      repeat (3) @(negedge i_mclk);
      chk(code, FCSP_CODE_RST);
      chk(mhz, FCSP_CODE_RST + 5'h01);
      i_host.xfer(1'b0, 5'h00, 5, q);
      chk(q, FCSP_CODE_RST);
      print_verdict;
   end
   initial
   begin
      #100us;
      num_errors++;
      print_verdict;
   end
endmodule // test_fcsp_port
bind fcsp_port fcsp_port_checker i_chk (.i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_serial_clk(i_serial_clk),
   .i_frame_select_n(i_frame_select_n), .o_serial_readback_out(o_serial_readback_out),
   .o_filter_corner_code(o_filter_corner_code), .o_corner_mhz(o_corner_mhz));
`default_nettype wire
